// ### rtl/tpa_consts.svh
// Purpose: offsets, field positions, reset values and counts of the transmit front end
// Assumes: included by its bare name from the design file
// Notes:   byte addresses on the register bus, one aligned 32-bit word each
//
// Summary of operation
// - capture eight data, two control bits
// - bypass: control bits are char bits 9:8
// - upper mode not low enables encoder
// - encoder on and lower mode not high captures special select
// - synchronous reference clocking bypasses align buffer
// - other clocking or double rate uses buffer
// - reset taken after two low reference edges
// - reset release centres buffer on phase
// - buffer reset pin synchronised before use
// - drift within half the buffer depth tolerated
// - skew overrun holds error until reset or recentring
// - error sends continuous violation characters
// - word sync in middle mode recentres
// - recentring may add or drop characters
// - mode selects are three-level, nine modes
// - error output also reports parity errors
`ifndef TPA_CONSTS_SVH
`define TPA_CONSTS_SVH

`define TPA_OFS_CTRL       8'h00
`define TPA_OFS_STATUS     8'h04
`define TPA_OFS_IRQ_STAT   8'h08
`define TPA_OFS_IRQ_MASK   8'h0C

`define TPA_CTRL_FORCE_RST 0
`define TPA_CTRL_PAR_OFF   1
`define TPA_CTRL_RESET     2'b00

`define TPA_IRQ_PHASE      0
`define TPA_IRQ_PARITY     1
`define TPA_IRQ_RECENTER   2
`define TPA_IRQ_RESET      3'b000

`define TPA_RST_EDGES      2'd2
`define TPA_VIOLATION_CHAR 10'b10_0111_1000
`define TPA_WORD_SYNC_CT   2'b11

`endif

// ### rtl/tpa_pkg.sv
// Purpose: types of the transmit front end
// Assumes: nothing
// Notes:   pin levels of three-level inputs arrive pre-decoded as two bits
package tpa_pkg;

  typedef enum logic [1:0] {
    TPA_LVL_LOW  = 2'b00,
    TPA_LVL_MID  = 2'b01,
    TPA_LVL_HIGH = 2'b10
  } tpa_level_t;

  typedef enum logic [2:0] {
    TPA_ST_RESET = 3'b001,
    TPA_ST_RUN   = 3'b010,
    TPA_ST_FAIL  = 3'b100
  } tpa_state_t;

endpackage

// ### rtl/tpa_tx_front.sv
// Purpose: transmit input register, phase-align buffer and error reporting
// Assumes: aclk much faster than reference and input clocks, both sampled as pins
// Notes:   registers over AXI4-Lite; characters leave on reference clock rising edges
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "tpa_consts.svh"

module tpa_tx_front
  import tpa_pkg::*;
#(
  parameter int DEPTH_LOG2 = 2
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // pins from the host
  input  wire logic        reference_clock,
  input  wire logic        tx_input_clock,
  input  wire logic [7:0]  tx_data_in,
  input  wire logic [1:0]  tx_control_bits,
  input  wire logic        special_char_select,
  input  wire logic        tx_parity_in,
  input  wire logic [1:0]  parity_mode_select,
  input  wire logic [1:0]  transmit_mode_select_hi,
  input  wire logic [1:0]  transmit_mode_select_lo,
  input  wire logic [1:0]  input_clock_select,
  input  wire logic        input_rate_select,
  input  wire logic        align_buffer_reset_n,
  // toward encoder and serializer
  output logic [9:0]       tx_char_out,
  output logic [1:0]       tx_char_ctrl,
  output logic             tx_char_special_sel,
  output logic             tx_char_violation,
  output logic             tx_char_valid,
  output logic             encoder_enable,
  output logic [3:0]       transmit_mode_index,
  output logic             tx_error_flag,
  output logic             irq,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int DEPTH = 1 << DEPTH_LOG2;
  localparam int PW    = DEPTH_LOG2 + 1;
  localparam int SW    = 24;

  // odd parity over the selected bits, result must be one
  function automatic logic parity_ok(input logic [11:0] e, input logic [1:0] pm, input logic enc);
    logic x;
    x = ^{e[7:0], e[11]};
    if (pm == TPA_LVL_HIGH || (pm == TPA_LVL_MID && !enc)) begin
      x = x ^ (^e[9:8]);
    end
    return (pm == TPA_LVL_LOW) ? 1'b1 : x;
  endfunction

  // three-level pin code to 0..2
  function automatic logic [3:0] lvl_num(input logic [1:0] l);
    return (l == TPA_LVL_HIGH) ? 4'h2 : ((l == TPA_LVL_MID) ? 4'h1 : 4'h0);
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [SW-1:0] sy1_r;
  logic [SW-1:0] sy2_r;
  logic [SW-1:0] sy_nxt;
  logic          ref_d_r;
  logic          in_d_r;
  logic          ref_nxt;
  logic          in_nxt;

  always_comb begin
    sy_nxt  = {reference_clock, tx_input_clock, tx_data_in, tx_control_bits, special_char_select,
               tx_parity_in, parity_mode_select, transmit_mode_select_hi, transmit_mode_select_lo,
               input_clock_select, input_rate_select, align_buffer_reset_n};
    ref_nxt = sy2_r[23];
    in_nxt  = sy2_r[22];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_r   <= '0;
      sy2_r   <= '0;
      ref_d_r <= 1'b0;
      in_d_r  <= 1'b0;
    end else if (clk_en) begin
      sy1_r   <= sy_nxt;
      sy2_r   <= sy1_r;
      ref_d_r <= ref_nxt;
      in_d_r  <= in_nxt;
    end
  end

  logic       ref_s;
  logic       in_s;
  logic [7:0] d_s;
  logic [1:0] ct_s;
  logic       sc_s;
  logic       op_s;
  logic [1:0] pm_s;
  logic [1:0] mhi_s;
  logic [1:0] mlo_s;
  logic [1:0] cks_s;
  logic       rate_s;
  logic       brst_n_s;
  assign {ref_s, in_s, d_s, ct_s, sc_s, op_s, pm_s, mhi_s, mlo_s, cks_s, rate_s, brst_n_s} = sy2_r;

  // ---------------- mode decode ----------------
  logic ref_rise;
  logic ref_fall;
  logic in_rise;
  logic in_fall;
  logic enc_on;
  logic bypass;
  logic cap_evt;
  logic [11:0] cap_ent;

  assign ref_rise = ref_s & ~ref_d_r;
  assign ref_fall = ~ref_s & ref_d_r;
  assign in_rise  = in_s & ~in_d_r;
  assign in_fall  = ~in_s & in_d_r;
  assign enc_on   = (mhi_s != TPA_LVL_LOW);
  assign bypass   = (cks_s == TPA_LVL_LOW) && !rate_s;
  // reference clock when selected, else uncontrolled input clock; double rate takes both edges
  assign cap_evt  = (cks_s == TPA_LVL_LOW) ? (ref_rise | (rate_s & ref_fall))
                                           : (in_rise | (rate_s & in_fall));
  // entry {parity, special select, control, data}
  assign cap_ent  = {op_s, (enc_on && mlo_s != TPA_LVL_HIGH) ? sc_s : 1'b0, ct_s, d_s};

  // ---------------- buffer reset and phase state ----------------
  logic [11:0]   mem_r [DEPTH];
  tpa_state_t    st_r;
  tpa_state_t    st_nxt;
  logic [PW-1:0] wp_r;
  logic [PW-1:0] wp_nxt;
  logic [PW-1:0] rp_r;
  logic [PW-1:0] rp_nxt;
  logic [1:0]    lowc_r;
  logic [1:0]    lowc_nxt;
  logic [PW-1:0] occ;
  logic [11:0]   rd_ent;
  logic          ev_phase;
  logic          ev_recenter;
  logic [1:0]    ctrl_r;

  assign occ    = wp_r - rp_r;
  assign rd_ent = mem_r[rp_r[DEPTH_LOG2-1:0]];

  always_comb begin
    st_nxt      = st_r;
    wp_nxt      = wp_r;
    rp_nxt      = rp_r;
    lowc_nxt    = lowc_r;
    ev_phase    = 1'b0;
    ev_recenter = 1'b0;
    if (ref_rise) begin
      // reset counts only after two consecutive low samples on reference edges
      lowc_nxt = (!brst_n_s || ctrl_r[`TPA_CTRL_FORCE_RST]) ?
                 ((lowc_r == `TPA_RST_EDGES) ? lowc_r : lowc_r + 2'd1) : 2'd0;
    end
    case (st_r)
      TPA_ST_RESET: begin
        // half-full on release: the present phase becomes the centre
        wp_nxt = PW'(DEPTH / 2);
        rp_nxt = '0;
        if (lowc_r != `TPA_RST_EDGES && !bypass) begin
          st_nxt = TPA_ST_RUN;
        end
      end
      TPA_ST_RUN: begin
        if (cap_evt) begin
          wp_nxt = wp_r + PW'(1);
        end
        if (ref_rise) begin
          rp_nxt = rp_r + PW'(1);
        end
        // half a buffer of slack each way before an overrun shows
        if ((cap_evt && !ref_rise && occ == PW'(DEPTH)) ||
            (ref_rise && !cap_evt && occ == '0)) begin
          st_nxt   = TPA_ST_FAIL;
          ev_phase = 1'b1;
          wp_nxt   = wp_r;
          rp_nxt   = rp_r;
        end
      end
      TPA_ST_FAIL: begin
        if (cap_evt) begin
          wp_nxt = wp_r + PW'(1);
        end
        if (ref_rise) begin
          rp_nxt = rp_r + PW'(1);
          // a word sync read out re-centres; entries in between are skipped or repeated
          if (mhi_s == TPA_LVL_MID && rd_ent[9:8] == `TPA_WORD_SYNC_CT) begin
            rp_nxt      = wp_nxt - PW'(DEPTH / 2);
            st_nxt      = TPA_ST_RUN;
            ev_recenter = 1'b1;
          end
        end
      end
      default: st_nxt = TPA_ST_RESET;
    endcase
    // buffer reset wins over overrun and recentring in the same cycle
    if (lowc_r == `TPA_RST_EDGES) begin
      st_nxt = TPA_ST_RESET;
      wp_nxt = PW'(DEPTH / 2);
      rp_nxt = '0;
    end
    if (bypass) begin
      st_nxt = TPA_ST_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= TPA_ST_RESET;
      wp_r   <= '0;
      rp_r   <= '0;
      lowc_r <= '0;
    end else if (clk_en) begin
      st_r   <= st_nxt;
      wp_r   <= wp_nxt;
      rp_r   <= rp_nxt;
      lowc_r <= lowc_nxt;
    end
  end

  // storage has no reset: contents are only read between the pointers
  always_ff @(posedge aclk) begin
    if (clk_en && cap_evt && !bypass) begin
      mem_r[wp_r[DEPTH_LOG2-1:0]] <= cap_ent;
    end
  end

  // ---------------- character output ----------------
  logic [11:0] src_ent;
  logic        par_bad;
  logic        ev_parity;
  logic [9:0]  ch_nxt;
  logic [1:0]  ct_nxt;
  logic        sel_nxt;
  logic        viol_nxt;
  logic        val_nxt;
  logic        perr_r;
  logic        perr_nxt;

  always_comb begin
    src_ent  = bypass ? cap_ent : rd_ent;
    par_bad  = !ctrl_r[`TPA_CTRL_PAR_OFF] && !parity_ok(src_ent, pm_s, enc_on);
    ev_parity = 1'b0;
    ch_nxt   = tx_char_out;
    ct_nxt   = tx_char_ctrl;
    sel_nxt  = tx_char_special_sel;
    viol_nxt = tx_char_violation;
    val_nxt  = 1'b0;
    perr_nxt = perr_r;
    if (ref_rise) begin
      val_nxt   = 1'b1;
      ev_parity = par_bad;
      perr_nxt  = par_bad;
      ch_nxt    = src_ent[9:0];
      ct_nxt    = src_ent[9:8];
      sel_nxt   = src_ent[10];
      viol_nxt  = par_bad || st_r != TPA_ST_RUN && !bypass;
      if (viol_nxt) begin
        ch_nxt = `TPA_VIOLATION_CHAR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_char_out         <= '0;
      tx_char_ctrl        <= '0;
      tx_char_special_sel <= 1'b0;
      tx_char_violation   <= 1'b0;
      tx_char_valid       <= 1'b0;
      perr_r              <= 1'b0;
    end else if (clk_en) begin
      tx_char_out         <= ch_nxt;
      tx_char_ctrl        <= ct_nxt;
      tx_char_special_sel <= sel_nxt;
      tx_char_violation   <= viol_nxt;
      tx_char_valid       <= val_nxt;
      perr_r              <= perr_nxt;
    end
  end

  assign encoder_enable      = enc_on;
  assign transmit_mode_index = 4'(lvl_num(mhi_s) * 4'd3 + lvl_num(mlo_s));
  assign tx_error_flag       = (st_r == TPA_ST_FAIL) || perr_r;

  // ---------------- register bus and interrupts ----------------
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic [2:0]  ist_r;
  logic [2:0]  imask_r;
  logic        bval_r;
  logic [1:0]  bresp_r;
  logic        rval_r;
  logic [31:0] rdat_r;
  logic [1:0]  rresp_r;
  logic        aw_got_nxt;
  logic        w_got_nxt;
  logic [7:0]  awa_nxt;
  logic [31:0] wd_nxt;
  logic [3:0]  ws_nxt;
  logic [1:0]  ctrl_nxt;
  logic [2:0]  ist_nxt;
  logic [2:0]  imask_nxt;
  logic        bval_nxt;
  logic [1:0]  bresp_nxt;
  logic        rval_nxt;
  logic [31:0] rdat_nxt;
  logic [1:0]  rresp_nxt;

  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready  = !w_got_r;
  assign s_axi_bvalid  = bval_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rval_r;
  assign s_axi_rvalid  = rval_r;
  assign s_axi_rdata   = rdat_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = |(ist_r & imask_r);

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    ctrl_nxt   = ctrl_r;
    ist_nxt    = ist_r;
    imask_nxt  = imask_r;
    bval_nxt   = bval_r;
    bresp_nxt  = bresp_r;
    rval_nxt   = rval_r;
    rdat_nxt   = rdat_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      awa_nxt    = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      wd_nxt    = s_axi_wdata;
      ws_nxt    = s_axi_wstrb;
    end
    if (bval_r && s_axi_bready) begin
      bval_nxt = 1'b0;
    end
    if (aw_got_r && w_got_r && !bval_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bval_nxt   = 1'b1;
      bresp_nxt  = 2'b00;
      case ({awa_r[7:2], 2'b00})
        `TPA_OFS_CTRL: begin
          if (ws_r[0]) begin
            ctrl_nxt = wd_r[1:0];
          end
        end
        `TPA_OFS_IRQ_MASK: begin
          if (ws_r[0]) begin
            imask_nxt = wd_r[2:0];
          end
        end
        `TPA_OFS_STATUS, `TPA_OFS_IRQ_STAT: bresp_nxt = 2'b00;
        default: bresp_nxt = 2'b10;
      endcase
    end
    if (rval_r && s_axi_rready) begin
      rval_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rval_r) begin
      rval_nxt  = 1'b1;
      rresp_nxt = 2'b00;
      case ({s_axi_araddr[7:2], 2'b00})
        `TPA_OFS_CTRL:     rdat_nxt = {30'h0, ctrl_r};
        `TPA_OFS_STATUS:   rdat_nxt = {16'h0, transmit_mode_index, 1'b0, bypass, enc_on, tx_error_flag,
                                       5'(occ), st_r};
        `TPA_OFS_IRQ_STAT: begin
          rdat_nxt = {29'h0, ist_r};
          ist_nxt  = 3'b000;
        end
        `TPA_OFS_IRQ_MASK: rdat_nxt = {29'h0, imask_r};
        default: begin
          rdat_nxt  = 32'h0000_0000;
          rresp_nxt = 2'b10;
        end
      endcase
    end
    // events set after any read-clear so a same-cycle event survives
    if (clk_en) begin
      ist_nxt = ist_nxt | {ev_recenter, ev_parity, ev_phase};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= '0;
      wd_r     <= '0;
      ws_r     <= '0;
      ctrl_r   <= `TPA_CTRL_RESET;
      ist_r    <= `TPA_IRQ_RESET;
      imask_r  <= `TPA_IRQ_RESET;
      bval_r   <= 1'b0;
      bresp_r  <= 2'b00;
      rval_r   <= 1'b0;
      rdat_r   <= '0;
      rresp_r  <= 2'b00;
    end else if (clk_en) begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awa_r    <= awa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      ctrl_r   <= ctrl_nxt;
      ist_r    <= ist_nxt;
      imask_r  <= imask_nxt;
      bval_r   <= bval_nxt;
      bresp_r  <= bresp_nxt;
      rval_r   <= rval_nxt;
      rdat_r   <= rdat_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

endmodule

// ### dv/tpa_host_model.sv
// Purpose: host logic presenting characters on the transmit pins
// Assumes: bench supplies the reference clock and the character to send
// Notes:   input clock is the reference shifted by phase_ns; run low parks it low
`timescale 1ns/100ps

module tpa_host_model (
  // from the bench
  input  wire logic       reference_clock,
  input  wire logic       run,
  input  wire logic [7:0] phase_ns,
  input  wire logic [9:0] char_val,
  input  wire logic       spc,
  input  wire logic       bad_par,
  // pins toward the device
  output logic            tx_input_clock,
  output logic [7:0]      tx_data_in,
  output logic [1:0]      tx_control_bits,
  output logic            special_char_select,
  output logic            tx_parity_in
);
  logic shifted_clk = 1'b0;

  // transport delay keeps both edges; drift under half a period keeps their order
  always @(reference_clock) shifted_clk <= #(phase_ns) reference_clock;
  assign tx_input_clock = shifted_clk & run;

  // new character after the falling edge, steady around the rising one
  always @(negedge shifted_clk) begin
    {tx_control_bits, tx_data_in} <= char_val;
    special_char_select <= spc;
    tx_parity_in <= ~(^char_val) ^ bad_par;
  end
endmodule

// ### dv/tpa_tx_front_chk.sv
// Purpose: port-level assertions of the transmit front end
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   special select is judged only once the mode pins have settled
`timescale 1ns/100ps
`include "tpa_consts.svh"

module tpa_tx_front_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // character side
  input wire logic [9:0]  tx_char_out,
  input wire logic        tx_char_special_sel,
  input wire logic        tx_char_violation,
  input wire logic        tx_char_valid,
  input wire logic        encoder_enable,
  input wire logic [3:0]  transmit_mode_index,
  input wire logic        tx_error_flag,
  input wire logic        irq,
  // register bus
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [5:0] age_r;
  logic [5:0] age_nxt;
  logic [3:0] idx_r;
  logic       spc_off;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // characters lag the pins by half the buffer depth, so wait long after a mode change
  assign spc_off = !encoder_enable || transmit_mode_index inside {4'h2, 4'h5, 4'h8};
  always_comb begin
    age_nxt = (transmit_mode_index != idx_r) ? 6'h00 : age_r + {5'h00, age_r != 6'h3f};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_r <= 6'h00;
      idx_r <= 4'h0;
    end else begin
      age_r <= age_nxt;
      idx_r <= transmit_mode_index;
    end
  end

  AST_ENC_TIE: assert property (encoder_enable == (transmit_mode_index >= 4'h3))
    else $error("encoder enable disagrees with mode index");
  AST_MODE_RANGE: assert property (transmit_mode_index <= 4'h8)
    else $error("mode index beyond nine modes");
  AST_SPECIAL_GATE: assert property (tx_char_valid && age_r == 6'h3f && spc_off |-> !tx_char_special_sel)
    else $error("special select passed in a mode that ignores it");
  AST_VIOL_CHAR: assert property (tx_char_valid && tx_char_violation |-> tx_char_out == `TPA_VIOLATION_CHAR)
    else $error("violation flagged with a wrong pattern");
  AST_CHAR_GAP: assert property (tx_char_valid |=> !tx_char_valid [*6])
    else $error("characters closer than one character period");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before rready");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed before bready");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h03
    |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_RST_QUIET: assert property ($rose(aresetn) |-> !(tx_error_flag || irq || tx_char_valid || s_axi_rvalid))
    else $error("outputs active right after reset");

  COV_VIOL: cover property (tx_char_valid && tx_char_violation);
  COV_ERR: cover property ($rose(tx_error_flag));
  COV_SPECIAL: cover property (tx_char_valid && tx_char_special_sel);
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

bind tpa_tx_front tpa_tx_front_chk u_tpa_tx_front_chk (
  .aclk, .aresetn, .tx_char_out, .tx_char_special_sel, .tx_char_violation, .tx_char_valid,
  .encoder_enable, .transmit_mode_index, .tx_error_flag, .irq, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready
);

// ### dv/tpa_tx_front_bench.sv
// Purpose: self-checking bench of the transmit front end
// Assumes: host model drives the character pins; reference clock made here
// Notes:   waits count characters, so align buffer latency does not matter
`timescale 1ns/100ps
`include "tpa_consts.svh"

`define CHK(act, exp) begin \
  tests_run++; \
  if ((act) !== (exp)) begin \
    n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, act, exp); \
  end \
end

module tpa_tx_front_bench;
  logic        aclk = 1'b0, aresetn = 1'b0, reference_clock = 1'b0, input_rate_select = 1'b0;
  logic        align_buffer_reset_n = 1'b1, run = 1'b1, spc = 1'b0, bad_par = 1'b0;
  logic [1:0]  parity_mode_select = 2'b00, transmit_mode_select_hi = 2'b00, transmit_mode_select_lo = 2'b00;
  logic [1:0]  input_clock_select = 2'b00, r, tx_control_bits, tx_char_ctrl, s_axi_bresp, s_axi_rresp;
  logic [7:0]  phase = 8'h3C, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data_in;
  logic [9:0]  char_val = 10'h2A5, tx_char_out;
  logic [31:0] s_axi_wdata = 32'h0000_0000, d, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, tx_input_clock, special_char_select, tx_parity_in, tx_char_special_sel;
  logic        tx_char_violation, tx_char_valid, encoder_enable, tx_error_flag, irq, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  transmit_mode_index;
  int          n_fail = 0, tests_run = 0;

  always #12.5 aclk = ~aclk;
  always #100 reference_clock = ~reference_clock;

  tpa_tx_front u_tpa_tx_front (
    .aclk, .aresetn, .clk_en(1'b1), .reference_clock, .tx_input_clock, .tx_data_in, .tx_control_bits,
    .special_char_select, .tx_parity_in, .parity_mode_select, .transmit_mode_select_hi,
    .transmit_mode_select_lo, .input_clock_select, .input_rate_select, .align_buffer_reset_n,
    .tx_char_out, .tx_char_ctrl, .tx_char_special_sel, .tx_char_violation, .tx_char_valid, .encoder_enable,
    .transmit_mode_index, .tx_error_flag, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  tpa_host_model u_tpa_host_model (
    .reference_clock, .run, .phase_ns(phase), .char_val, .spc, .bad_par,
    .tx_input_clock, .tx_data_in, .tx_control_bits, .special_char_select, .tx_parity_in
  );

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // values read right after an edge are the ones that edge sampled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (s_axi_bvalid !== 1'b1 && t < 50);
    if (t >= 50) n_fail++;
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, 2'b00)
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (s_axi_rvalid !== 1'b1 && t < 50);
    if (t >= 50) n_fail++;
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_chars(input int n);
    int t = 0;
    repeat (n) begin
      @(posedge aclk);
      while (tx_char_valid !== 1'b1 && t < 400) begin
        @(posedge aclk);
        t++;
      end
    end
    if (t >= 400) n_fail++;
  endtask

  task automatic buf_reset(input int n);
    @(posedge aclk);
    align_buffer_reset_n <= 1'b0;
    repeat (n) @(posedge aclk);
    align_buffer_reset_n <= 1'b1;
  endtask

  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TPA_OFS_STATUS, d, r);
    `CHK({d[10], d[2:0]}, 4'h9)
    axi_rd(`TPA_OFS_IRQ_MASK, d, r);
    `CHK(d[2:0], `TPA_IRQ_RESET)
    axi_wr(`TPA_OFS_CTRL, 32'h0000_0002);
    axi_rd(`TPA_OFS_CTRL, d, r);
    `CHK(d[1:0], 2'b10)
    axi_wr(`TPA_OFS_CTRL, 32'h0000_0000);
    axi_rd(8'h40, d, r);
    `CHK({r, d}, {2'b10, 32'h0000_0000})
    spc <= 1'b1;
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        transmit_mode_select_hi <= 2'(h);
        transmit_mode_select_lo <= 2'(l);
        wait_chars(6);
        `CHK(transmit_mode_index, 4'(h * 3 + l))
        `CHK(encoder_enable, 1'(h != 0))
        `CHK(tx_char_special_sel, 1'(h != 0 && l != 2))
        `CHK(tx_char_ctrl, 2'b10)
        if (h == 0) `CHK(tx_char_out, 10'h2A5)
      end
    end
    spc <= 1'b0;
    transmit_mode_select_hi <= 2'b00;
    transmit_mode_select_lo <= 2'b00;
    for (int i = 0; i < 4; i++) begin
      input_clock_select <= (i == 1) ? 2'b01 : (i == 2) ? 2'b10 : 2'b00;
      input_rate_select <= (i == 3);
      wait_chars(2);
      axi_rd(`TPA_OFS_STATUS, d, r);
      `CHK(d[10], 1'(i == 0))
    end
    input_clock_select <= 2'b01;
    input_rate_select <= 1'b0;
    buf_reset(40);
    wait_chars(8);
    axi_rd(`TPA_OFS_STATUS, d, r);
    `CHK(d[2:0], 3'b010)
    `CHK(tx_char_out, 10'h2A5)
    phase <= 8'h8C;
    wait_chars(20);
    `CHK({tx_error_flag, tx_char_violation}, 2'b00)
    // a pulse shorter than a reference period must not reset the buffer
    buf_reset(2);
    wait_chars(6);
    axi_rd(`TPA_OFS_STATUS, d, r);
    `CHK(d[2:0], 3'b010)
    run <= 1'b0;
    wait_chars(8);
    `CHK({tx_error_flag, tx_char_violation, irq}, 3'b110)
    `CHK(tx_char_out, `TPA_VIOLATION_CHAR)
    axi_wr(`TPA_OFS_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    run <= 1'b1;
    wait_chars(10);
    `CHK({tx_error_flag, tx_char_violation}, 2'b11)
    transmit_mode_select_hi <= 2'b01;
    char_val <= 10'h3BC;
    wait_chars(8);
    transmit_mode_select_hi <= 2'b00;
    char_val <= 10'h2A5;
    wait_chars(8);
    `CHK({tx_error_flag, tx_char_violation}, 2'b00)
    `CHK(tx_char_out, 10'h2A5)
    axi_rd(`TPA_OFS_IRQ_STAT, d, r);
    `CHK(d[2:0], 3'b101)
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    input_clock_select <= 2'b00;
    parity_mode_select <= 2'b10;
    wait_chars(4);
    `CHK(tx_error_flag, 1'b0)
    bad_par <= 1'b1;
    wait_chars(4);
    `CHK({tx_error_flag, tx_char_violation}, 2'b11)
    `CHK(tx_char_out, `TPA_VIOLATION_CHAR)
    axi_wr(`TPA_OFS_CTRL, 32'h0000_0002);
    wait_chars(4);
    `CHK(tx_error_flag, 1'b0)
    wrap_up;
  end
endmodule
